//--- hw/gpio_pkg.sv
// Constants, register indices and pin capability maps of the six-port pin block.
package gpio_pkg;

    localparam int NUM_PORTS     = 6;
    localparam int PORT_W        = 8;
    localparam int PIN_W         = 48;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;
    localparam int GROUPS        = 4;
    localparam int REGS_PER_PORT = 3;
    localparam int KIND_DATA     = 0;
    localparam int KIND_DIR      = 1;
    localparam int KIND_OPT      = 2;

    // Register indices; the APB byte address is four times the index.
    localparam logic [5:0] IDX_PORT_A_DATA      = 6'h00;
    localparam logic [5:0] IDX_PORT_A_DIRECTION = 6'h01;
    localparam logic [5:0] IDX_PORT_A_OPTION    = 6'h02;
    localparam logic [5:0] IDX_PORT_B_DATA      = 6'h03;
    localparam logic [5:0] IDX_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] IDX_PORT_B_OPTION    = 6'h05;
    localparam logic [5:0] IDX_PORT_C_DATA      = 6'h06;
    localparam logic [5:0] IDX_PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] IDX_PORT_C_OPTION    = 6'h08;
    localparam logic [5:0] IDX_PORT_D_DATA      = 6'h09;
    localparam logic [5:0] IDX_PORT_D_DIRECTION = 6'h0A;
    localparam logic [5:0] IDX_PORT_D_OPTION    = 6'h0B;
    localparam logic [5:0] IDX_PORT_E_DATA      = 6'h0C;
    localparam logic [5:0] IDX_PORT_E_DIRECTION = 6'h0D;
    localparam logic [5:0] IDX_PORT_E_OPTION    = 6'h0E;
    localparam logic [5:0] IDX_PORT_F_DATA      = 6'h0F;
    localparam logic [5:0] IDX_PORT_F_DIRECTION = 6'h10;
    localparam logic [5:0] IDX_PORT_F_OPTION    = 6'h11;
    localparam logic [5:0] IDX_INT_STATUS       = 6'h12;
    localparam logic [5:0] IDX_INT_MASK         = 6'h13;

    localparam logic [7:0]          REG_RESET    = 8'h00;
    localparam logic [GROUPS-1:0]   GROUP_RESET  = 4'h0;
    localparam logic [PIN_W-1:0]    PIN_RESET    = 48'h0000_0000_0000;
    localparam logic [DATA_W-1:0]   BUS_RESET    = 32'h0000_0000;

    // Pin maps: bit port*8+n, port A at the bottom, port F at the top.
    localparam logic [PIN_W-1:0] IRQ_FLOAT_PINS = 48'h0400_0000_8808;
    localparam logic [PIN_W-1:0] IRQ_PULL_PINS  = 48'h0300_0000_7707;
    localparam logic [PIN_W-1:0] TRUE_OD_PINS   = 48'h0000_0000_00C0;
    localparam logic [PIN_W-1:0] FORCE_PU_PINS  = 48'h0004_0000_0000;

    // Pins feeding each external interrupt vector group.
    localparam logic [GROUPS-1:0][PIN_W-1:0] GROUP_PINS = {
        48'h0000_0000_F000,
        48'h0000_0000_0F00,
        48'h0700_0000_0000,
        48'h0000_0000_000F
    };

    typedef enum logic [1:0]
    {
        SENS_LOW_LEVEL,
        SENS_RISING,
        SENS_FALLING,
        SENS_BOTH
    } sens_type;

endpackage : gpio_pkg

//--- hw/gpio_ports.sv
// Six eight-bit general-purpose ports with APB registers and external interrupts.
`timescale 1ns/1ps

module gpio_ports
(
    input  wire logic                                 clk,        // 40 MHz clock
    input  wire logic                                 nrst,       // Synchronous reset, low
    input  wire logic                                 psel,       // APB select
    input  wire logic                                 penable,    // APB access phase
    input  wire logic                                 pwrite,     // APB write
    input  wire logic [gpio_pkg::ADDR_W-1:0]          paddr,      // APB byte address
    input  wire logic [gpio_pkg::DATA_W-1:0]          pwdata,     // APB write data
    output logic      [gpio_pkg::DATA_W-1:0]          prdata,     // APB read data
    output logic                                      pready,     // APB ready
    output logic                                      pslverr,    // APB error
    input  wire logic [gpio_pkg::PIN_W-1:0]           pin_in,     // Pad input levels
    output logic      [gpio_pkg::PIN_W-1:0]           pin_out,    // Pad output value
    output logic      [gpio_pkg::PIN_W-1:0]           pin_oe,     // Pad output enable
    output logic      [gpio_pkg::PIN_W-1:0]           pin_pullup, // Pad pull-up enable
    input  wire logic [gpio_pkg::PIN_W-1:0]           alt_en,     // Peripheral owns pin
    input  wire logic [gpio_pkg::PIN_W-1:0]           alt_out,    // Peripheral output value
    input  wire logic [gpio_pkg::PIN_W-1:0]           alt_pp,     // Peripheral wants push-pull
    input  wire logic [2*gpio_pkg::GROUPS-1:0]        ext_irq_sensitivity_ctrl, // Per group
    input  wire logic                                 cc_irq_mask,  // CPU interrupt mask
    input  wire logic [gpio_pkg::GROUPS-1:0]          vector_fetch, // Vector fetched, pulse
    output logic      [gpio_pkg::GROUPS-1:0]          ext_irq_req,  // Request to CPU
    output logic                                      wake_req,     // Leave Wait or Halt
    output logic                                      irq           // Status interrupt
);
    import gpio_pkg::*;

    logic [PORT_W-1:0]       data_q [NUM_PORTS];
    logic [PORT_W-1:0]       dir_q  [NUM_PORTS];
    logic [PORT_W-1:0]       opt_q  [NUM_PORTS];
    logic [PIN_W-1:0]        data_v;
    logic [PIN_W-1:0]        dir_v;
    logic [PIN_W-1:0]        opt_v;
    logic [PIN_W-1:0]        pin_meta_q;
    logic [PIN_W-1:0]        pin_sync_q;
    logic [PIN_W-1:0]        pin_prev_q;
    logic [PIN_W-1:0]        eff_dir;
    logic [PIN_W-1:0]        eff_pp;
    logic [PIN_W-1:0]        drive_val;
    logic [PIN_W-1:0]        read_val;
    logic [PIN_W-1:0]        irq_en;
    logic [GROUPS-1:0]       hit;
    logic [GROUPS-1:0]       req_q;
    logic [2*GROUPS-1:0]     sens_prev_q;
    logic [GROUPS-1:0]       status_q;
    logic [GROUPS-1:0]       int_mask_q;
    logic [DATA_W-1:0]       prdata_q;
    logic                    slverr_q;
    logic [DATA_W-1:0]       rd_data;
    logic [5:0]              idx;
    logic                    addr_ok;
    logic                    setup_ph;
    logic                    access_ph;
    logic                    wr_en;
    logic                    rd_clear;

    function automatic logic [5:0] reg_idx(input int p, input int k);
        reg_idx = 6'(int'(IDX_PORT_A_DATA) + p * REGS_PER_PORT + k);
    endfunction : reg_idx

    // Detects events per pin by the group sensitivity and ORs the enabled ones.
    function automatic logic group_hit
    (
        input logic [PIN_W-1:0] en,
        input logic [PIN_W-1:0] cur,
        input logic [PIN_W-1:0] prev,
        input logic [1:0]       sens
    );
        logic [PIN_W-1:0] ev;
        ev = PIN_RESET;
        unique case (sens_type'(sens))
            SENS_LOW_LEVEL: ev = ~cur;
            SENS_RISING:    ev = cur & ~prev;
            SENS_FALLING:   ev = ~cur & prev;
            SENS_BOTH:      ev = cur ^ prev;
        endcase
        group_hit = |(ev & en);
    endfunction : group_hit

    // APB decode; no wait states, read data is registered in the setup phase so it comes from a flip-flop.
    assign idx       = paddr[7:2];
    assign addr_ok   = (paddr[1:0] == 2'b00) && (idx <= IDX_INT_MASK);
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign wr_en     = access_ph && pwrite && addr_ok;
    assign rd_clear  = access_ph && !pwrite && (idx == IDX_INT_STATUS);
    assign pready    = access_ph;
    assign pslverr   = access_ph && slverr_q;
    assign prdata    = prdata_q;

    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            data_v[p*PORT_W +: PORT_W] = data_q[p];
            dir_v[p*PORT_W +: PORT_W]  = dir_q[p];
            opt_v[p*PORT_W +: PORT_W]  = opt_q[p];
        end
    end

    // Configuration registers, three per port in ascending order.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                data_q[p] <= REG_RESET;
                dir_q[p]  <= REG_RESET;
                opt_q[p]  <= REG_RESET;
            end
        end
        else if (wr_en)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (idx == reg_idx(p, KIND_DATA))
                    data_q[p] <= pwdata[PORT_W-1:0];
                if (idx == reg_idx(p, KIND_DIR))
                    dir_q[p] <= pwdata[PORT_W-1:0];
                if (idx == reg_idx(p, KIND_OPT))
                    opt_q[p] <= pwdata[PORT_W-1:0];
            end
        end
    end

    // An input pin reads the pad, or the peripheral output when one owns the pin.
    assign read_val = (dir_v & data_v)
                    | (~dir_v & alt_en & alt_out)
                    | (~dir_v & ~alt_en & pin_sync_q);

    always_comb
    begin
        rd_data = BUS_RESET;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (idx == reg_idx(p, KIND_DATA))
                rd_data[PORT_W-1:0] = read_val[p*PORT_W +: PORT_W];
            if (idx == reg_idx(p, KIND_DIR))
                rd_data[PORT_W-1:0] = dir_q[p];
            if (idx == reg_idx(p, KIND_OPT))
                rd_data[PORT_W-1:0] = opt_q[p];
        end
        if (idx == IDX_INT_STATUS)
            rd_data[GROUPS-1:0] = status_q;
        if (idx == IDX_INT_MASK)
            rd_data[GROUPS-1:0] = int_mask_q;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            prdata_q <= BUS_RESET;
            slverr_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_q <= addr_ok ? rd_data : BUS_RESET;
            slverr_q <= !addr_ok;
        end
    end

    // Pad control; a claiming peripheral overrides direction, value and drive type.
    assign eff_dir   = dir_v | alt_en;
    assign eff_pp    = eff_dir & ~TRUE_OD_PINS & ((alt_en & alt_pp) | (~alt_en & opt_v));
    assign drive_val = (alt_en & alt_out) | (~alt_en & data_v);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pin_out    <= PIN_RESET;
            pin_oe     <= PIN_RESET;
            pin_pullup <= FORCE_PU_PINS;
        end
        else
        begin
            pin_out    <= drive_val & eff_pp;
            pin_oe     <= eff_dir & (eff_pp | ~drive_val);
            pin_pullup <= (~eff_dir & opt_v & ~TRUE_OD_PINS & ~IRQ_FLOAT_PINS)
                        | FORCE_PU_PINS;
        end
    end

    // Two-stage synchroniser; only pin_sync_q and later stages feed logic.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pin_meta_q <= PIN_RESET;
            pin_sync_q <= PIN_RESET;
            pin_prev_q <= PIN_RESET;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Interrupt mode comes from direction and option, on capable pins that no peripheral owns.
    assign irq_en = ~dir_v & opt_v & (IRQ_FLOAT_PINS | IRQ_PULL_PINS) & ~alt_en;

    always_comb
    begin
        for (int g = 0; g < GROUPS; g++)
            hit[g] = group_hit(irq_en & GROUP_PINS[g], pin_sync_q, pin_prev_q,
                               ext_irq_sensitivity_ctrl[2*g +: 2]);
    end

    // Hidden request latches: cleared by vector fetch or a sensitivity change.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            req_q       <= GROUP_RESET;
            sens_prev_q <= 8'h00;
        end
        else
        begin
            sens_prev_q <= ext_irq_sensitivity_ctrl;
            for (int g = 0; g < GROUPS; g++)
            begin
                if (hit[g])
                    req_q[g] <= 1'b1;
                else if (vector_fetch[g] ||
                         (ext_irq_sensitivity_ctrl[2*g +: 2] != sens_prev_q[2*g +: 2]))
                    req_q[g] <= 1'b0;
            end
        end
    end

    assign ext_irq_req = req_q & {GROUPS{!cc_irq_mask}};
    assign wake_req    = |req_q;

    // Sticky status, cleared only for the bits the read returned; new events win.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            status_q   <= GROUP_RESET;
            int_mask_q <= GROUP_RESET;
        end
        else
        begin
            status_q <= (status_q & ~(rd_clear ? prdata_q[GROUPS-1:0] : GROUP_RESET)) | hit;
            if (wr_en && (idx == IDX_INT_MASK))
                int_mask_q <= pwdata[GROUPS-1:0];
        end
    end

    assign irq = |(status_q & int_mask_q);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence apb_dir_a_write;
        psel && !penable && pwrite && (paddr[7:2] == IDX_PORT_A_DIRECTION)
            && (paddr[1:0] == 2'b00) ##1 psel && penable;
    endsequence

    sequence apb_data_a_read;
        psel && !penable && !pwrite && (paddr == 8'h00) && (dir_q[0] == REG_RESET);
    endsequence

    map_write_a: assert property (apb_dir_a_write |=> dir_q[0] == $past(pwdata[7:0]))
        else $error("Port A direction write did not land at its index");

    reset_clear_a: assert property (@(posedge clk) !nrst |=>
            (dir_v == PIN_RESET) && (opt_v == PIN_RESET) && (data_v == PIN_RESET))
        else $error("Port registers not cleared by reset");

    pin_read_a: assert property (apb_data_a_read |=> prdata_q[7:0] == $past(read_val[7:0])
            && (prdata_q[7:0] == ($past(alt_en[7:0] & alt_out[7:0])
            | $past(~alt_en[7:0] & pin_sync_q[7:0]))))
        else $error("Input port read did not return the pin level");

    sync_delay_a: assert property ($past(nrst) && $past(nrst, 2) |->
            pin_sync_q == $past(pin_in, 2))
        else $error("Pin level not delayed by two stages");

    od_low_a: assert property (dir_v[16] && !opt_v[16] && !data_v[16] && !alt_en[16]
            |=> pin_oe[16] && !pin_out[16])
        else $error("Open-drain zero does not pull low");

    od_float_a: assert property (dir_v[16] && !opt_v[16] && data_v[16] && !alt_en[16]
            |=> !pin_oe[16])
        else $error("Open-drain one is driven");

    pp_high_a: assert property (dir_v[24] && opt_v[24] && data_v[24] && !alt_en[24]
            |=> pin_oe[24] && pin_out[24] && !pin_pullup[24])
        else $error("Push-pull one not driven high");

    true_od_a: assert property ($past(nrst) |-> (pin_out[7:6] == 2'b00)
            && !pin_pullup[7] && !pin_pullup[6])
        else $error("True open-drain pin driven high or pulled up");

    e2_pullup_a: assert property ($past(nrst) |-> pin_pullup[34])
        else $error("Port E pin two lost its pull-up");

    float_irq_a: assert property (!dir_v[3] && opt_v[3] && !alt_en[3] |=> !pin_pullup[3])
        else $error("Floating interrupt pin is pulled up");

    pull_irq_a: assert property (!dir_v[0] && opt_v[0] && !alt_en[0] |=> pin_pullup[0])
        else $error("Pulled interrupt pin lacks pull-up");

    irq_gate_a: assert property (cc_irq_mask |-> ext_irq_req == GROUP_RESET)
        else $error("Request passed a masked CPU");

    mode_gate_a: assert property (opt_v[0] == 1'b0 && opt_v[1] == 1'b0 && opt_v[2] == 1'b0
            && opt_v[3] == 1'b0 |-> !hit[0])
        else $error("Group fired without interrupt mode");

    vec_clear_a: assert property (req_q[0] && vector_fetch[0] && !hit[0] |=> !req_q[0])
        else $error("Vector fetch did not clear request");

    wake_a: assert property (hit[1] |=> wake_req)
        else $error("Pin event did not request wake-up");

endmodule : gpio_ports

//--- verification/pad_model.sv
// Pad model that resolves each pin level from the block, the pull-ups and an outside source.
`timescale 1ns/1ps

module pad_model
(
    input  wire logic                       clk,        // Bench clock
    input  wire logic [gpio_pkg::PIN_W-1:0] pin_out,    // Block output value
    input  wire logic [gpio_pkg::PIN_W-1:0] pin_oe,     // Block drives the pad
    input  wire logic [gpio_pkg::PIN_W-1:0] pin_pullup, // Pull-up enabled
    input  wire logic [gpio_pkg::PIN_W-1:0] ext_en,     // Outside source drives the pad
    input  wire logic [gpio_pkg::PIN_W-1:0] ext_val,    // Outside source value
    output logic      [gpio_pkg::PIN_W-1:0] pin_level   // Resolved pad level
);
    import gpio_pkg::*;

    logic [PIN_W-1:0] last_q;

    // A pad that nobody drives and nothing pulls up shows the inverse of its last level.
    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = ~last_q[i];
        end
    end

    always_ff @(posedge clk)
    begin
        last_q <= pin_level;
    end
endmodule : pad_model

//--- verification/six_port_pin_config_block_tb_top.sv
// Self-checking bench for the six-port pin block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); mismatches++; end end

module six_port_pin_config_block_tb_top;
    import gpio_pkg::*;

    logic              clk;
    logic              nrst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [PIN_W-1:0]  pin_in;
    logic [PIN_W-1:0]  pin_out;
    logic [PIN_W-1:0]  pin_oe;
    logic [PIN_W-1:0]  pin_pullup;
    logic [PIN_W-1:0]  ext_val;
    logic [7:0]        sens;
    logic              cc_irq_mask;
    logic [3:0]        vector_fetch;
    logic [3:0]        ext_irq_req;
    logic              wake_req;
    logic              irq;
    logic [31:0]       rv;
    logic              err;
    int                mismatches;
    int                n_tests;
    int                p;
    // Columns: port, data, direction, option, expected enable, pull-up, driven-high pins.
    logic [7:0] rows [0:9][0:6] = '{
        '{8'h00, 8'h00, 8'hF0, 8'hFF, 8'hF0, 8'h07, 8'h00},
        '{8'h00, 8'hC0, 8'hC0, 8'hC0, 8'h00, 8'h00, 8'h00},
        '{8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h77, 8'h00},
        '{8'h02, 8'h0F, 8'hFF, 8'hF0, 8'hF0, 8'h00, 8'h00},
        '{8'h03, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00},
        '{8'h03, 8'h3C, 8'hFF, 8'h0F, 8'hCF, 8'h00, 8'h0C},
        '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00},
        '{8'h04, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h04, 8'h00},
        '{8'h05, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFB, 8'h00},
        '{8'h05, 8'hA5, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hA5}
    };

    gpio_ports dut_u
    (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .alt_en(48'h0), .alt_out(48'h0), .alt_pp(48'h0),
        .ext_irq_sensitivity_ctrl(sens), .cc_irq_mask(cc_irq_mask),
        .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req), .wake_req(wake_req),
        .irq(irq)
    );

    pad_model pads_u
    (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en({PIN_W{1'b1}}), .ext_val(ext_val), .pin_level(pin_in)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic serr);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            mismatches++;
            tally_and_finish();
        end
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input int pt, input int k, input logic [7:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, 8'(4 * (3 * pt + k)), {24'h0, d}, x, e);
    endtask : wr

    task automatic rd(input int pt, input int k, output logic [31:0] x);
        logic e;
        apb(1'b0, 8'(4 * (3 * pt + k)), 32'h0, x, e);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic check_reset();
        logic [31:0] x;
        logic [31:0] ex;
        settle(1);
        `CHK("oe", 48'h0, pin_oe);
        `CHK("pullup", 48'h0004_0000_0000, pin_pullup);
        for (int i = 0; i < 18; i++)
        begin
            rd(i / 3, i % 3, x);
            // Input pins read the pad level, so a data register shows the outside source.
            ex = (i % 3 == 0) ? {24'h0, ext_val[8*(i/3)+:8]} : 32'h0;
            `CHK("reg", ex, x);
        end
        $display("test reset done");
    endtask : check_reset

    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_val = {6{8'hA5}};
        sens = 8'h00;
        cc_irq_mask = 1'b0;
        vector_fetch = 4'h0;
        mismatches = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        check_reset();
        for (int r = 0; r < 10; r++)
        begin
            p = rows[r][0];
            wr(p, KIND_DATA, rows[r][1]);
            wr(p, KIND_OPT, rows[r][3]);
            wr(p, KIND_DIR, rows[r][2]);
            settle(3);
            `CHK("oe", rows[r][4], pin_oe[p*8+:8]);
            `CHK("pullup", rows[r][5], pin_pullup[p*8+:8]);
            `CHK("high", rows[r][6], pin_out[p*8+:8] & pin_oe[p*8+:8]);
            rd(p, KIND_OPT, rv);
            `CHK("option", {24'h0, rows[r][3]}, rv);
            rd(p, KIND_DATA, rv);
            `CHK("data", {24'h0, (rows[r][2] & rows[r][1]) | (~rows[r][2] & 8'hA5)}, rv);
        end
        $display("test modes done");
        apb(1'b0, 8'h50, 32'h0, rv, err);
        `CHK("unmapped err", 1'b1, err);
        `CHK("unmapped data", 32'h0, rv);
        apb(1'b1, 8'h05, 32'hFF, rv, err);
        `CHK("misaligned err", 1'b1, err);
        rd(0, KIND_DIR, rv);
        `CHK("dir kept", 32'hC0, rv);
        $display("test refusal done");
        wr(0, KIND_OPT, 8'h00);
        wr(0, KIND_DIR, 8'h00);
        apb(1'b1, 8'h4C, 32'h1, rv, err);
        // Changing every group's sensitivity drops latches left by the mode rows.
        @(posedge clk) sens <= 8'hAA;
        settle(1);
        apb(1'b0, 8'h48, 32'h0, rv, err);
        @(posedge clk) ext_val[0] <= 1'b0;
        settle(4);
        `CHK("no wake", 1'b0, wake_req);
        `CHK("no req", 4'h0, ext_irq_req);
        @(posedge clk) ext_val[0] <= 1'b1;
        settle(4);
        wr(0, KIND_OPT, 8'h01);
        @(posedge clk) ext_val[0] <= 1'b0;
        settle(4);
        `CHK("req", 4'h1, ext_irq_req);
        `CHK("irq", 1'b1, irq);
        @(posedge clk) cc_irq_mask <= 1'b1;
        settle(1);
        `CHK("masked req", 4'h0, ext_irq_req);
        `CHK("wake", 1'b1, wake_req);
        apb(1'b1, 8'h4C, 32'h0, rv, err);
        settle(1);
        `CHK("irq off", 1'b0, irq);
        apb(1'b1, 8'h4C, 32'h1, rv, err);
        settle(1);
        `CHK("irq on", 1'b1, irq);
        @(posedge clk) vector_fetch <= 4'h1;
        @(posedge clk) vector_fetch <= 4'h0;
        settle(1);
        `CHK("fetch clears", 1'b0, wake_req);
        apb(1'b0, 8'h48, 32'h0, rv, err);
        `CHK("status", 32'h1, rv);
        apb(1'b0, 8'h48, 32'h0, rv, err);
        `CHK("status cleared", 32'h0, rv);
        `CHK("irq cleared", 1'b0, irq);
        cc_irq_mask <= 1'b0;
        $display("test interrupt done");
        @(posedge clk) nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        check_reset();
        tally_and_finish();
    end
endmodule : six_port_pin_config_block_tb_top
